// ===== core/cpsf_core.v
// status flags, pointers and special registers behind an ahb-lite slave
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "cpsf_defines.vh"

module cpsf_core #(
  parameter SECT_W = 1,
  parameter PC_W = 13
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire wdt_timeout,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp
);

  localparam AW = 8 + SECT_W, DEPTH = 256 << SECT_W;
  localparam ST_IDLE = 2'h0, ST_EXEC = 2'h1, ST_DUMMY = 2'h2;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // sector above, offset below
  // port 0 pinned to sector zero
  function [AW-1:0] resolve;
    input [AW-1:0] a;
    input [7:0] p0;
    input [7:0] p1l;
    input [7:0] p1h;
    begin
      if (a[7:0] == `CPSF_SP_INDIRECT_PORT_0) begin
        resolve = {{SECT_W{1'h0}}, p0};
      end else if (a[7:0] == `CPSF_SP_INDIRECT_PORT_1) begin
        resolve = {p1h[SECT_W-1:0], p1l};
      end else begin
        resolve = a;
      end
    end
  endfunction

  function is_port;
    input [7:0] off;
    begin
      is_port = (off == `CPSF_SP_INDIRECT_PORT_0) || (off == `CPSF_SP_INDIRECT_PORT_1);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] dmem_reg [0:DEPTH-1];
  reg [7:0] flags_reg, flags_next, acc_reg, acc_next;
  reg [7:0] mp0_reg, pointer1_low_reg, pointer1_sector_select_reg, table_pointer_low_reg, table_pointer_high_reg, table_read_high_byte_reg;
  reg [PC_W-1:0] pc_reg;
  reg [1:0] state_reg;
  reg [3:0] op_reg;
  reg [AW-1:0] caddr_reg;
  reg wdt_s1_reg, wdt_s2_reg, wdt_s3_reg;
  reg ap_wr_reg, rd_pend_reg, hreadyout_reg, hresp_reg;
  reg [7:0] ap_addr_reg;
  reg [31:0] hrdata_reg, bus_rd;
  reg [7:0] rd_val, wdat;
  reg mem_we;

  wire exec = (state_reg == ST_EXEC);
  wire [AW-1:0] eff = resolve(caddr_reg, mp0_reg, pointer1_low_reg, pointer1_sector_select_reg);
  wire eff_port = is_port(eff[7:0]);
  wire eff_sp = (eff[7:0] < `CPSF_SP_TOP);
  wire acc_phase = hsel & htrans[1] & hready;
  wire wr_commit = ap_wr_reg;
  wire wdt_rise = wdt_s2_reg & ~wdt_s3_reg;
  wire pcl_wr = mem_we & eff_sp & (eff[7:0] == `CPSF_SP_PCL);
  wire [15:0] tbl_ptr = {table_pointer_high_reg, table_pointer_low_reg};
  wire [15:0] rom_data;
  wire [7:0] alu_res;
  wire alu_c, alu_ac, alu_z, alu_ov, alu_sc, alu_cz;
  wire upd_arith, upd_c, upd_z, upd_cz;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  cpsf_alu cpsf_alu_inst (
    .op(op_reg),
    .a(acc_reg),
    .b(rd_val),
    .cin(flags_reg[`CPSF_FLG_C]),
    .czin(flags_reg[`CPSF_FLG_CZ]),
    .res(alu_res),
    .c(alu_c), .ac(alu_ac), .z(alu_z), .ov(alu_ov), .sc(alu_sc), .cz(alu_cz),
    .upd_arith(upd_arith), .upd_c(upd_c), .upd_z(upd_z), .upd_cz(upd_cz)
  );

  cpsf_prog_rom #(
    .AW(PC_W)
  ) cpsf_prog_rom_inst (
    .addr(tbl_ptr[PC_W-1:0]),
    .data(rom_data)
  );

  // ----------------------------------------
  // operand read and result write select
  // ----------------------------------------
  always @* begin
    // port seen as itself reads zero
    if (eff_port) begin
      rd_val = 8'h00;
    end else if (eff_sp) begin
      case (eff[7:0])
        `CPSF_SP_MP0: rd_val = mp0_reg;
        `CPSF_SP_POINTER1_LOW: rd_val = pointer1_low_reg;
        `CPSF_SP_POINTER1_SECTOR_SELECT: rd_val = pointer1_sector_select_reg;
        `CPSF_SP_ACC: rd_val = acc_reg;
        `CPSF_SP_PCL: rd_val = pc_reg[7:0];
        `CPSF_SP_TABLE_POINTER_LOW: rd_val = table_pointer_low_reg;
        `CPSF_SP_TABLE_POINTER_HIGH: rd_val = table_pointer_high_reg;
        `CPSF_SP_TABLE_READ_HIGH_BYTE: rd_val = table_read_high_byte_reg;
        `CPSF_SP_FLAGS: rd_val = flags_reg;
        default: rd_val = 8'h00;
      endcase
    end else begin
      rd_val = dmem_reg[eff];
    end
  end

  always @* begin
    wdat = alu_res;
    mem_we = 1'h0;
    case (op_reg)
      `CPSF_OP_MOVM: begin
        wdat = acc_reg;
        mem_we = exec;
      end
      `CPSF_OP_INC, `CPSF_OP_DEC: begin
        mem_we = exec;
      end
      `CPSF_OP_TABRD: begin
        wdat = rom_data[7:0];
        mem_we = exec;
      end
      default: mem_we = 1'h0;
    endcase
    // writes to a port as itself do nothing
    if (eff_port) begin
      mem_we = 1'h0;
    end
  end

  // ----------------------------------------
  // flag and work register next values
  // ----------------------------------------
  always @* begin
    flags_next = flags_reg;
    acc_next = acc_reg;
    if (wr_commit && ap_addr_reg == `CPSF_OFF_FLAGS) begin
      flags_next[3:0] = hwdata[3:0];
    end
    if (wr_commit && ap_addr_reg == `CPSF_OFF_ACC) begin
      acc_next = hwdata[7:0];
    end
    if (exec) begin
      // only low four bits are writable
      if (mem_we && eff_sp && eff[7:0] == `CPSF_SP_FLAGS) begin
        flags_next[3:0] = wdat[3:0];
      end
      if (mem_we && eff_sp && eff[7:0] == `CPSF_SP_ACC) begin
        acc_next = wdat;
      end
      // alu result lands in work register
      if (op_reg < `CPSF_OP_MOVM) begin
        acc_next = alu_res;
      end else if (op_reg == `CPSF_OP_MOVA) begin
        acc_next = rd_val;
      end
      // flags take effect with this execute
      if (upd_arith) begin
        flags_next[`CPSF_FLG_C] = alu_c;
        flags_next[`CPSF_FLG_AC] = alu_ac;
        flags_next[`CPSF_FLG_OV] = alu_ov;
        flags_next[`CPSF_FLG_SC] = alu_sc;
      end
      if (upd_c) begin
        flags_next[`CPSF_FLG_C] = alu_c;
      end
      if (upd_z) begin
        flags_next[`CPSF_FLG_Z] = alu_z;
      end
      if (upd_cz) begin
        flags_next[`CPSF_FLG_CZ] = alu_cz;
      end
      if (op_reg == `CPSF_OP_HALT) begin
        flags_next[`CPSF_FLG_PDF] = 1'h1;
        flags_next[`CPSF_FLG_TO] = 1'h0;
      end else if (op_reg == `CPSF_OP_CLRWDT) begin
        flags_next[`CPSF_FLG_PDF] = 1'h0;
        flags_next[`CPSF_FLG_TO] = 1'h0;
      end
    end
    if (wdt_rise) begin
      flags_next[`CPSF_FLG_TO] = 1'h1;
    end
  end

  // ----------------------------------------
  // execution registers
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // flags live only here, no stack copy
      flags_reg <= `CPSF_FLAGS_RST;
      acc_reg <= 8'h00;
      mp0_reg <= 8'h00;
      pointer1_low_reg <= 8'h00;
      pointer1_sector_select_reg <= 8'h00;
      table_pointer_low_reg <= 8'h00;
      table_pointer_high_reg <= 8'h00;
      table_read_high_byte_reg <= 8'h00;
      pc_reg <= {PC_W{1'h0}};
      state_reg <= ST_IDLE;
      op_reg <= 4'h0;
      caddr_reg <= {AW{1'h0}};
    end else begin
      flags_reg <= flags_next;
      acc_reg <= acc_next;
      case (state_reg)
        ST_IDLE: begin
          if (wr_commit && ap_addr_reg == `CPSF_OFF_CMD) begin
            op_reg <= hwdata[`CPSF_CMD_OP_MSB:0];
            caddr_reg <= hwdata[`CPSF_CMD_ADDR_LSB+AW-1:`CPSF_CMD_ADDR_LSB];
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          pc_reg <= pc_reg + {{(PC_W-1){1'h0}}, 1'h1};
          state_reg <= ST_IDLE;
          // jump inside page plus dummy cycle
          if (pcl_wr) begin
            pc_reg <= {pc_reg[PC_W-1:8], wdat};
            state_reg <= ST_DUMMY;
          end
          if (mem_we && eff_sp) begin
            case (eff[7:0])
              `CPSF_SP_MP0: mp0_reg <= wdat;
              `CPSF_SP_POINTER1_LOW: pointer1_low_reg <= wdat;
              `CPSF_SP_POINTER1_SECTOR_SELECT: pointer1_sector_select_reg <= wdat;
              `CPSF_SP_TABLE_POINTER_LOW: table_pointer_low_reg <= wdat;
              `CPSF_SP_TABLE_POINTER_HIGH: table_pointer_high_reg <= wdat;
              `CPSF_SP_TABLE_READ_HIGH_BYTE: table_read_high_byte_reg <= wdat;
              default: table_read_high_byte_reg <= table_read_high_byte_reg;
            endcase
          end
          if (op_reg == `CPSF_OP_TABRD) begin
            table_read_high_byte_reg <= rom_data[15:8];
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // general data memory, no reset on storage
  always @(posedge hclk) begin
    if (mem_we && !eff_sp) begin
      dmem_reg[eff] <= wdat;
    end
  end

  // ----------------------------------------
  // watchdog time-out synchroniser
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_s1_reg <= 1'h0;
      wdt_s2_reg <= 1'h0;
      wdt_s3_reg <= 1'h0;
    end else begin
      wdt_s1_reg <= wdt_timeout;
      wdt_s2_reg <= wdt_s1_reg;
      wdt_s3_reg <= wdt_s2_reg;
    end
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  always @* begin
    case (ap_addr_reg)
      `CPSF_OFF_FLAGS: bus_rd = {24'h000000, flags_reg};
      `CPSF_OFF_ACC: bus_rd = {24'h000000, acc_reg};
      `CPSF_OFF_CMD: bus_rd = {31'h00000000, state_reg != ST_IDLE};
      `CPSF_OFF_PC: bus_rd = {{(32-PC_W){1'h0}}, pc_reg};
      default: bus_rd = 32'h00000000;
    endcase
  end

  // reads take one wait state so a write just before is seen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg <= 1'h0;
      ap_addr_reg <= 8'h00;
      rd_pend_reg <= 1'h0;
      hreadyout_reg <= 1'h1;
      hresp_reg <= 1'h0;
      hrdata_reg <= 32'h00000000;
    end else begin
      ap_wr_reg <= acc_phase & hwrite & (hsize == `CPSF_HSIZE_WORD);
      if (acc_phase) begin
        ap_addr_reg <= haddr[7:0];
      end
      if (rd_pend_reg) begin
        hrdata_reg <= bus_rd;
        hreadyout_reg <= 1'h1;
        rd_pend_reg <= 1'h0;
      end else if (acc_phase && !hwrite) begin
        hreadyout_reg <= 1'h0;
        rd_pend_reg <= 1'h1;
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

endmodule
`default_nettype wire

// ===== common/cpsf_defines.vh
// constants for the status flag and pointer core
`ifndef CPSF_DEFINES_VH
`define CPSF_DEFINES_VH

// ----------------------------------------
// bus register byte offsets
// ----------------------------------------
`define CPSF_OFF_FLAGS 8'h00
`define CPSF_OFF_ACC 8'h04
`define CPSF_OFF_CMD 8'h08
`define CPSF_OFF_PC 8'h0C
`define CPSF_HSIZE_WORD 3'h2

// ----------------------------------------
// command word fields
// ----------------------------------------
`define CPSF_CMD_OP_MSB 3
`define CPSF_CMD_ADDR_LSB 8

// ----------------------------------------
// flag bit positions and reset value
// ----------------------------------------
`define CPSF_FLG_C 0
`define CPSF_FLG_AC 1
`define CPSF_FLG_Z 2
`define CPSF_FLG_OV 3
`define CPSF_FLG_PDF 4
`define CPSF_FLG_TO 5
`define CPSF_FLG_CZ 6
`define CPSF_FLG_SC 7
`define CPSF_FLAGS_RST 8'h00

// ----------------------------------------
// operation codes
// ----------------------------------------
`define CPSF_OP_ADD 4'h0
`define CPSF_OP_ADC 4'h1
`define CPSF_OP_SUB 4'h2
`define CPSF_OP_SBC 4'h3
`define CPSF_OP_AND 4'h4
`define CPSF_OP_OR 4'h5
`define CPSF_OP_XOR 4'h6
`define CPSF_OP_RLC 4'h7
`define CPSF_OP_MOVA 4'h8
`define CPSF_OP_MOVM 4'h9
`define CPSF_OP_INC 4'hA
`define CPSF_OP_DEC 4'hB
`define CPSF_OP_TABRD 4'hC
`define CPSF_OP_HALT 4'hD
`define CPSF_OP_CLRWDT 4'hE

// ----------------------------------------
// special data memory offsets (in every sector)
// ----------------------------------------
`define CPSF_SP_INDIRECT_PORT_0 8'h00
`define CPSF_SP_MP0 8'h01
`define CPSF_SP_INDIRECT_PORT_1 8'h02
`define CPSF_SP_POINTER1_LOW 8'h03
`define CPSF_SP_POINTER1_SECTOR_SELECT 8'h04
`define CPSF_SP_ACC 8'h05
`define CPSF_SP_PCL 8'h06
`define CPSF_SP_TABLE_POINTER_LOW 8'h07
`define CPSF_SP_TABLE_POINTER_HIGH 8'h08
`define CPSF_SP_TABLE_READ_HIGH_BYTE 8'h09
`define CPSF_SP_FLAGS 8'h0A
`define CPSF_SP_TOP 8'h10

`endif

// ===== core/cpsf_alu.v
// eight-bit arithmetic unit with flag outputs
`timescale 1ns/100ps
`default_nettype none
`include "cpsf_defines.vh"

module cpsf_alu (
  input wire [3:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire cin,
  input wire czin,
  output reg [7:0] res,
  output reg c,
  output reg ac,
  output reg z,
  output reg ov,
  output reg sc,
  output reg cz,
  output reg upd_arith,
  output reg upd_c,
  output reg upd_z,
  output reg upd_cz
);

  reg [7:0] bx;
  reg ci;
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] low7;

  always @* begin
    bx = b;
    ci = 1'h0;
    if (op == `CPSF_OP_ADC) begin
      ci = cin;
    end else if (op == `CPSF_OP_SUB) begin
      bx = ~b;
      ci = 1'h1;
    end else if (op == `CPSF_OP_SBC) begin
      bx = ~b;
      ci = cin;
    end
    sum = {1'h0, a} + {1'h0, bx} + {8'h00, ci};
    nib = {1'h0, a[3:0]} + {1'h0, bx[3:0]} + {4'h0, ci};
    low7 = {1'h0, a[6:0]} + {1'h0, bx[6:0]} + {7'h00, ci};
    res = sum[7:0];
    c = sum[8];
    ac = nib[4];
    ov = low7[7] ^ sum[8];
    upd_arith = 1'h0;
    upd_c = 1'h0;
    upd_z = 1'h0;
    upd_cz = 1'h0;
    case (op)
      `CPSF_OP_ADD, `CPSF_OP_ADC: begin
        upd_arith = 1'h1;
        upd_z = 1'h1;
      end
      `CPSF_OP_SUB, `CPSF_OP_SBC: begin
        upd_arith = 1'h1;
        upd_z = 1'h1;
        upd_cz = 1'h1;
      end
      `CPSF_OP_AND: begin
        res = a & b;
        upd_z = 1'h1;
      end
      `CPSF_OP_OR: begin
        res = a | b;
        upd_z = 1'h1;
      end
      `CPSF_OP_XOR: begin
        res = a ^ b;
        upd_z = 1'h1;
      end
      `CPSF_OP_RLC: begin
        res = {b[6:0], cin};
        c = b[7];
        upd_c = 1'h1;
      end
      `CPSF_OP_INC: begin
        res = b + 8'h01;
        upd_z = 1'h1;
      end
      `CPSF_OP_DEC: begin
        res = b - 8'h01;
        upd_z = 1'h1;
      end
      default: begin
        res = b;
      end
    endcase
    z = (res == 8'h00);
    sc = ov ^ res[7];
    cz = (op == `CPSF_OP_SBC) ? (czin & z) : z;
  end

endmodule
`default_nettype wire

// ===== core/cpsf_prog_rom.v
// program memory lookup table for table reads
`timescale 1ns/100ps
`default_nettype none

module cpsf_prog_rom #(
  parameter AW = 13
) (
  input wire [AW-1:0] addr,
  output reg [15:0] data
);

  // fixed pattern from the low address byte only, so words are distinct within each 256-word block and repeat beyond it
  always @* begin
    data = {addr[7:0] ^ 8'hA5, addr[7:0]};
  end

endmodule
`default_nettype wire

// ===== tb/cpsf_core_checker.sv
// bus and flag assertions for the status flag core
`timescale 1ns/100ps
`default_nettype none
`include "cpsf_defines.vh"
module cpsf_core_checker #(
  parameter PC_W = 13
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic wdt_timeout,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  // ----------------------------------------
  // transfer tracking
  // ----------------------------------------
  logic taken, rd_done, rd_pend, wr_pend, halt_seen, wdt_seen;
  logic [7:0] ph_addr;
  assign taken = hsel && htrans[1] && hready;
  assign rd_done = rd_pend && hreadyout;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      halt_seen <= 1'b0;
      wdt_seen <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      if (rd_done) rd_pend <= 1'b0;
      if (wr_pend && hready) wr_pend <= 1'b0;
      // a halt command written in the data phase
      if (wr_pend && hready && ph_addr == `CPSF_OFF_CMD && hwdata[3:0] == `CPSF_OP_HALT)
        halt_seen <= 1'b1;
      if (wdt_timeout) wdt_seen <= 1'b1;
      if (taken) begin
        rd_pend <= !hwrite;
        wr_pend <= hwrite;
        ph_addr <= haddr[7:0];
      end
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_TO_CAUSE: assert property (
    rd_done && ph_addr == `CPSF_OFF_FLAGS && hrdata[5] |-> wdt_seen)
    else $error("time-out flag set without watchdog event");
  AST_PDF_CAUSE: assert property (
    rd_done && ph_addr == `CPSF_OFF_FLAGS && hrdata[4] |-> halt_seen)
    else $error("sleep flag set without halt");
  AST_PC_RANGE: assert property (
    rd_done && ph_addr == `CPSF_OFF_PC |-> hrdata[31:PC_W] == '0)
    else $error("program counter wider than its field");
  AST_ACC_BYTE: assert property (
    rd_done && ph_addr == `CPSF_OFF_ACC |-> hrdata[31:8] == 24'h000000)
    else $error("work register upper bits not zero");
  AST_FLAGS_BYTE: assert property (
    rd_done && ph_addr == `CPSF_OFF_FLAGS |-> hrdata[31:8] == 24'h000000)
    else $error("flag register upper bits not zero");
  AST_GAP_ZERO: assert property (
    rd_done && ph_addr >= 8'h10 |-> hrdata == 32'h00000000)
    else $error("unmapped offset read not zero");
  AST_WR_NO_WAIT: assert property (
    taken && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_RD_ONE_WAIT: assert property (
    taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not exactly one cycle");
  AST_DATA_HOLD: assert property (
    hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed outside a read");
  AST_RESP_OKAY: assert property (
    !hresp)
    else $error("error response seen");
  cover property (rd_done && ph_addr == `CPSF_OFF_FLAGS && hrdata[5]);
  cover property (rd_done && ph_addr == `CPSF_OFF_FLAGS && hrdata[4]);
  cover property (taken && hwrite && haddr[7:0] == `CPSF_OFF_CMD);
endmodule
bind cpsf_core cpsf_core_checker #(.PC_W(PC_W)) cpsf_core_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .wdt_timeout(wdt_timeout),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// ===== tb/cpu_status_flags_and_pointers_tb.sv
// self-checking bench for the status flag core
`timescale 1ns/100ps
`default_nettype none
`include "cpsf_defines.vh"
module cpu_status_flags_and_pointers_tb;
  logic hclk, hresetn, hsel, hwrite, wdt_timeout;
  logic [31:0] haddr, hwdata, rdat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata;
  wire hreadyout, hresp;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [3:0] op;
  logic [7:0] a, m, ef;
  logic ci;
  logic [15:0] ex;
  logic [20:0] rows [11];
  cpsf_core cpsf_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .wdt_timeout(wdt_timeout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      wrap_up;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, ad};
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdat = hrdata;
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d, `CPSF_HSIZE_WORD);
  endtask
  task rd(input logic [7:0] ad);
    xfer(1'b0, ad, 32'h00000000, `CPSF_HSIZE_WORD);
  endtask
  task cmd(input logic [3:0] o, input logic [8:0] ad);
    wr(`CPSF_OFF_CMD, {15'h0000, ad, 4'h0, o});
    rdat = 32'h00000001;
    for (int k = 0; k < 8 && rdat[0] !== 1'b0; k++) rd(`CPSF_OFF_CMD);
    chk({31'h0, rdat[0]}, 32'h00000000);
  endtask
  task setm(input logic [8:0] ad, input logic [7:0] v);
    wr(`CPSF_OFF_ACC, {24'h000000, v});
    cmd(`CPSF_OP_MOVM, ad);
  endtask
  task getm(input logic [8:0] ad, input logic [7:0] e);
    cmd(`CPSF_OP_MOVA, ad);
    rd(`CPSF_OFF_ACC);
    chk(rdat, {24'h000000, e});
  endtask
  task pwr(input logic [1:0] e);
    rd(`CPSF_OFF_FLAGS);
    chk({30'h00000000, rdat[5:4]}, {30'h00000000, e});
  endtask
  // model: {flags, result} of one operation on work register and memory
  function automatic logic [15:0] model(input logic [3:0] o, input logic [7:0] x, y, f);
    logic [7:0] b, r;
    logic [8:0] s;
    logic [4:0] h;
    logic c0, ov, z;
    b = (o == `CPSF_OP_SUB || o == `CPSF_OP_SBC) ? ~y : y;
    c0 = (o == `CPSF_OP_ADD) ? 1'b0 : (o == `CPSF_OP_SUB) ? 1'b1 : f[0];
    s = x + b + c0;
    h = x[3:0] + b[3:0] + c0;
    r = s[7:0];
    ov = (x[7] == b[7]) && (r[7] != x[7]);
    z = (r == 8'h00);
    model = {r[7] ^ ov, f[6:4], ov, z, h[4], s[8], r};
    if (o == `CPSF_OP_SUB) model[14] = z;
    if (o == `CPSF_OP_SBC) model[14] = f[6] & z;
    if (o > `CPSF_OP_SBC) begin
      r = (o == `CPSF_OP_AND) ? x & y : (o == `CPSF_OP_OR) ? x | y :
          (o == `CPSF_OP_XOR) ? x ^ y : {y[6:0], f[0]};
      model = {f, r};
      if (o == `CPSF_OP_RLC) model[8] = y[7];
      else model[10] = (r == 8'h00);
    end
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `CPSF_HSIZE_WORD;
    hwdata = 32'h00000000;
    wdt_timeout = 1'b0;
    rows = '{{`CPSF_OP_ADD, 8'h7F, 8'h01, 1'h0}, {`CPSF_OP_ADD, 8'hFF, 8'h01, 1'h0},
      {`CPSF_OP_ADC, 8'h0F, 8'h00, 1'h1}, {`CPSF_OP_SUB, 8'h05, 8'h05, 1'h0},
      {`CPSF_OP_SBC, 8'h00, 8'h00, 1'h1}, {`CPSF_OP_SBC, 8'h01, 8'h00, 1'h1},
      {`CPSF_OP_SUB, 8'h80, 8'h01, 1'h0}, {`CPSF_OP_AND, 8'hF0, 8'h0F, 1'h0},
      {`CPSF_OP_OR, 8'h00, 8'h00, 1'h1}, {`CPSF_OP_XOR, 8'h5A, 8'h3C, 1'h0},
      {`CPSF_OP_RLC, 8'h00, 8'h81, 1'h0}};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`CPSF_OFF_FLAGS);
    chk(rdat, 32'h00000000);
    rd(`CPSF_OFF_PC);
    chk(rdat, 32'h00000000);
    ef = 8'h00;
    foreach (rows[i]) begin
      {op, a, m, ci} = rows[i];
      setm(9'h020, m);
      wr(`CPSF_OFF_FLAGS, {24'h000000, 4'hF, 3'h0, ci});
      ef[3:0] = {3'h0, ci};
      wr(`CPSF_OFF_ACC, {24'h000000, a});
      cmd(op, 9'h020);
      ex = model(op, a, m, ef);
      ef = ex[15:8];
      rd(`CPSF_OFF_ACC);
      chk(rdat, {24'h000000, ex[7:0]});
      rd(`CPSF_OFF_FLAGS);
      chk(rdat, {24'h000000, ef});
      chk({31'h0, rdat[`CPSF_FLG_AC]}, {31'h0, ef[`CPSF_FLG_AC]});
      chk({31'h0, rdat[`CPSF_FLG_Z]}, {31'h0, ef[`CPSF_FLG_Z]});
      chk({31'h0, rdat[`CPSF_FLG_OV]}, {31'h0, ef[`CPSF_FLG_OV]});
      chk({31'h0, rdat[`CPSF_FLG_SC]}, {31'h0, ef[`CPSF_FLG_SC]});
      chk({31'h0, rdat[`CPSF_FLG_CZ]}, {31'h0, ef[`CPSF_FLG_CZ]});
      $display("row %0d done", i);
    end
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10);
    chk(rdat, 32'h00000000);
    wr(`CPSF_OFF_ACC, 32'h00000011);
    xfer(1'b1, `CPSF_OFF_ACC, 32'h00000022, 3'h0);
    rd(`CPSF_OFF_ACC);
    chk(rdat, 32'h00000011);
    $display("bus refusal test done");
    setm(9'h001, 8'h30);
    setm(9'h000, 8'h77);
    getm(9'h030, 8'h77);
    setm(9'h003, 8'h30);
    setm(9'h004, 8'h01);
    setm(9'h002, 8'h99);
    getm(9'h130, 8'h99);
    getm(9'h030, 8'h77);
    getm(9'h002, 8'h99);
    setm(9'h001, 8'h00);
    setm(9'h000, 8'h55);
    getm(9'h000, 8'h00);
    $display("indirect test done");
    setm(9'h007, 8'h12);
    setm(9'h008, 8'h00);
    cmd(`CPSF_OP_TABRD, 9'h040);
    getm(9'h009, 8'hB7);
    getm(9'h040, 8'h12);
    cmd(`CPSF_OP_INC, 9'h007);
    cmd(`CPSF_OP_TABRD, 9'h040);
    getm(9'h040, 8'h13);
    $display("table test done");
    setm(9'h006, 8'h40);
    rd(`CPSF_OFF_PC);
    chk(rdat, 32'h00000040);
    $display("jump test done");
    cmd(`CPSF_OP_HALT, 9'h000);
    pwr(2'h1);
    @(posedge hclk) wdt_timeout <= 1'b1;
    repeat (4) @(posedge hclk);
    wdt_timeout <= 1'b0;
    pwr(2'h3);
    wr(`CPSF_OFF_FLAGS, 32'h00000000);
    pwr(2'h3);
    cmd(`CPSF_OP_HALT, 9'h000);
    pwr(2'h1);
    cmd(`CPSF_OP_CLRWDT, 9'h000);
    pwr(2'h0);
    $display("power flag test done");
    wrap_up;
  end
endmodule
`default_nettype wire
